// ==== core/aic_map.svh ====
// Register offsets, field positions, reset values and timing figures of the
// analog input conditioning block. Included by the design files by bare name.
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH

// Per-channel register indices; byte address = base + 4 * index.
`define AIC_CH1_BASE     12'h000
`define AIC_CH2_BASE     12'h040
`define AIC_IDX_CFG      4'h0
`define AIC_IDX_TRIG     4'h1
`define AIC_IDX_ZERO     4'h2
`define AIC_IDX_GAIN     4'h3
`define AIC_IDX_XOFF     4'h4
`define AIC_IDX_YOFF     4'h5
`define AIC_IDX_MIN      4'h6
`define AIC_IDX_MAX      4'h7
`define AIC_IDX_PRE      4'h8
`define AIC_IDX_POST     4'h9
`define AIC_OFF_ROUTE    12'h080
`define AIC_OFF_REF      12'h084
`define AIC_OFF_AUX      12'h088

// Fields of the per-channel configuration word.
`define AIC_CFG_RANGE_LSB 0
`define AIC_CFG_AVG_LSB   2
`define AIC_CFG_HOLD_BIT  8
`define AIC_AVG_CODE_MAX  3'h6
`define AIC_TRIG_W        12

// Reset values; percentages are in 0.1 % units, gain in 0.01 units.
`define AIC_RST_CFG      16'h0000
`define AIC_RST_GAIN     16'h0064
`define AIC_RST_OFFSET   16'h0000
`define AIC_RST_MIN      16'hf060
`define AIC_RST_MAX      16'h0fa0
`define AIC_GAIN_SCALE   32'sh00000064
`define AIC_SAT_POS      32'sh00000fa0
`define AIC_SAT_NEG      32'shfffff060
`define AIC_LIVE_ZERO    32'sh000000c8

// Timing: 2 ms sample period at a 4 ns clock.
`define AIC_SAMPLE_PERIOD_NS 32'h001e8480
`define AIC_CLK_PERIOD_NS    32'h00000004

`endif

// ==== core/aic_pkg.sv ====
// Types shared by the analog input conditioning design files.
// Assumes nothing of its surroundings.
package aic_pkg;

  typedef logic signed [15:0] aic_val_type;

  typedef enum logic [1:0] {
    AIC_RANGE_V10    = 2'h0,
    AIC_RANGE_MA20   = 2'h1,
    AIC_RANGE_MA4_20 = 2'h2
  } aic_range_type;

  typedef enum logic [2:0] {
    AIC_S_IDLE  = 3'h0,
    AIC_S_RANGE = 3'h1,
    AIC_S_AVG   = 3'h2,
    AIC_S_HOLD  = 3'h3,
    AIC_S_ZERO  = 3'h4,
    AIC_S_AMP   = 3'h5,
    AIC_S_LIMIT = 3'h6,
    AIC_S_ROUTE = 3'h7
  } aic_state_type;

endpackage : aic_pkg

// ==== core/aic_hist_mem.sv ====
// Sample history memory for the running mean, one write and one read port.
// Assumes one clock; read data come from a register one cycle after raddr.
module aic_hist_mem #(
  parameter int unsigned WIDTH  = 16,
  parameter int unsigned ADDR_W = 7
) (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem_r [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end

endmodule : aic_hist_mem

// ==== core/aic_analog_cond.sv ====
// Two-channel analog reference conditioning chain with an AXI4-Lite slave.
// Assumes converter codes in 0.1 % of full scale that stay stable for many
// clocks around each 2 ms sample, and asynchronous digital input pins.
// Summary of operation
// - Each channel's range code picks 10 V bipolar (0), 20 mA bipolar (1) or 4-20 mA (2).
// - With averaging off each channel is sampled every 2 ms and passed on unchanged.
// - The filter code selects no averaging (0) or a mean of 2, 4, 8, 16, 32 or 64 samples.
// - Each channel has a save mode, enabled in its configuration and keyed by a chosen input.
// - In save mode a high trigger passes and stores the signal; a low one replays the store.
// - A zero clamp forces values within a symmetric band of up to 10 % around zero to zero.
// - A negative band also acts as hysteresis, taking only setpoint changes larger than it.
// - After the clamp each channel passes an amplifier with x offset, y offset and gain.
// - The amplifier gives gain times input minus x offset plus y offset; default gain is 1.00.
// - Each amplifier output is clamped to its minimum and maximum, without ordering check.
// - Every internal value saturates at plus and minus 400 % of full scale.
// - A route setting picks which channel drives the reference and which the auxiliary value.
// - Each channel shows read-only monitors before and after the amplifier.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`include "aic_map.svh"

module aic_analog_cond
  import aic_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `AIC_SAMPLE_PERIOD_NS / `AIC_CLK_PERIOD_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] analog_channel_one,
  input  wire logic [15:0] analog_channel_two,
  input  wire logic [11:0] prog_inputs,
  output logic [15:0]      ref_value,
  output logic [15:0]      aux_value,
  output logic             value_valid
);

  function automatic aic_val_type sat_val(input logic signed [31:0] x);
    if (x > `AIC_SAT_POS) begin
      return aic_val_type'(`AIC_SAT_POS);
    end else if (x < `AIC_SAT_NEG) begin
      return aic_val_type'(`AIC_SAT_NEG);
    end
    return aic_val_type'(x);
  endfunction : sat_val

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Converter codes and pins cross in through two flip-flops each.
  logic        [15:0] adc_meta_r [2];
  aic_val_type        adc_sync_r [2];
  logic        [11:0] din_meta_r;
  logic        [11:0] din_sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_meta_r <= '{default: '0};
      adc_sync_r <= '{default: '0};
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      adc_meta_r[0] <= analog_channel_one;
      adc_meta_r[1] <= analog_channel_two;
      adc_sync_r[0] <= adc_meta_r[0];
      adc_sync_r[1] <= adc_meta_r[1];
      din_meta_r    <= prog_inputs;
      din_sync_r    <= din_meta_r;
    end
  end

  logic [31:0] tick_cnt_r;
  logic        tick_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == SAMPLE_CYCLES - 1) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  logic [15:0] cfg_r  [2];
  logic [15:0] trig_r [2];
  aic_val_type zero_r [2];
  aic_val_type gain_r [2];
  aic_val_type xoff_r [2];
  aic_val_type yoff_r [2];
  aic_val_type min_r  [2];
  aic_val_type max_r  [2];
  aic_val_type mon_pre_r  [2];
  aic_val_type mon_post_r [2];
  logic        route_r;
  aic_val_type ref_r;
  aic_val_type aux_r;
  logic        valid_r;

  // Write side: address and data are taken together once both are offered.
  logic       wr_fire;
  logic       wr_map;
  logic       wr_route;
  logic       wr_ch;
  logic [3:0] wr_idx;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_ch   = s_axi_awaddr[6];
  assign wr_idx  = s_axi_awaddr[5:2];

  always_comb begin
    wr_map   = 1'b0;
    wr_route = 1'b0;
    if (s_axi_awaddr[11:7] == 5'h00 && wr_idx <= `AIC_IDX_POST) begin
      wr_map = 1'b1;
    end else if ({s_axi_awaddr[11:2], 2'h0} == `AIC_OFF_ROUTE) begin
      wr_map   = 1'b1;
      wr_route = 1'b1;
    end else if ({s_axi_awaddr[11:2], 2'h0} == `AIC_OFF_REF ||
                 {s_axi_awaddr[11:2], 2'h0} == `AIC_OFF_AUX) begin
      wr_map = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch_regs
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_r[c]  <= `AIC_RST_CFG;
        trig_r[c] <= '0;
        zero_r[c] <= `AIC_RST_OFFSET;
        gain_r[c] <= `AIC_RST_GAIN;
        xoff_r[c] <= `AIC_RST_OFFSET;
        yoff_r[c] <= `AIC_RST_OFFSET;
        min_r[c]  <= `AIC_RST_MIN;
        max_r[c]  <= `AIC_RST_MAX;
      end else if (wr_fire && wr_map && !wr_route && wr_ch == 1'(c)) begin
        if (wr_idx == `AIC_IDX_CFG) begin
          cfg_r[c] <= merge16(cfg_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_TRIG) begin
          trig_r[c] <= merge16(trig_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_ZERO) begin
          zero_r[c] <= merge16(zero_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_GAIN) begin
          gain_r[c] <= merge16(gain_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_XOFF) begin
          xoff_r[c] <= merge16(xoff_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_YOFF) begin
          yoff_r[c] <= merge16(yoff_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_MIN) begin
          min_r[c] <= merge16(min_r[c], s_axi_wdata, s_axi_wstrb);
        end else if (wr_idx == `AIC_IDX_MAX) begin
          max_r[c] <= merge16(max_r[c], s_axi_wdata, s_axi_wstrb);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r <= 1'b0;
    end else if (wr_fire && wr_route && s_axi_wstrb[0]) begin
      route_r <= s_axi_wdata[0];
    end
  end

  // Read side.
  logic        rd_fire;
  logic        rd_ok;
  logic [31:0] rd_data;
  logic        rd_ch;
  logic [3:0]  rd_idx;

  assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign rd_ch   = s_axi_araddr[6];
  assign rd_idx  = s_axi_araddr[5:2];

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = '0;
    if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_CFG) begin
      rd_data[15:0] = cfg_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_TRIG) begin
      rd_data[15:0] = trig_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_ZERO) begin
      rd_data[15:0] = zero_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_GAIN) begin
      rd_data[15:0] = gain_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_XOFF) begin
      rd_data[15:0] = xoff_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_YOFF) begin
      rd_data[15:0] = yoff_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_MIN) begin
      rd_data[15:0] = min_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_MAX) begin
      rd_data[15:0] = max_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_PRE) begin
      rd_data[15:0] = mon_pre_r[rd_ch];
    end else if (s_axi_araddr[11:7] == 5'h00 && rd_idx == `AIC_IDX_POST) begin
      rd_data[15:0] = mon_post_r[rd_ch];
    end else if ({s_axi_araddr[11:2], 2'h0} == `AIC_OFF_ROUTE) begin
      rd_data[0] = route_r;
    end else if ({s_axi_araddr[11:2], 2'h0} == `AIC_OFF_REF) begin
      rd_data[15:0] = ref_r;
    end else if ({s_axi_araddr[11:2], 2'h0} == `AIC_OFF_AUX) begin
      rd_data[15:0] = aux_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Datapath: one working value walks the stages, channel one then two.
  aic_state_type state_r;
  logic          ch_r;
  aic_val_type   val_r;
  logic [5:0]    ptr_r  [2];
  logic [6:0]    fill_r [2];
  logic [23:0]   sum_r  [2];
  logic [2:0]    seen_r [2];
  aic_val_type   held_r [2];
  aic_val_type   last_r [2];
  logic [15:0]   old_sample;

  logic [2:0]         code_cur;
  logic [6:0]         n_cur;
  logic               restart;
  logic signed [23:0] sum_nxt;
  logic [6:0]         fill_nxt;
  aic_val_type        rng_nxt;
  aic_val_type        avg_nxt;
  aic_val_type        hold_nxt;
  aic_val_type        zero_nxt;
  aic_val_type        amp_nxt;
  aic_val_type        lim_nxt;
  aic_val_type        band;
  logic               trig_hit;
  logic               hold_en;

  assign code_cur = (cfg_r[ch_r][`AIC_CFG_AVG_LSB +: 3] > `AIC_AVG_CODE_MAX) ?
                    `AIC_AVG_CODE_MAX : cfg_r[ch_r][`AIC_CFG_AVG_LSB +: 3];
  assign n_cur    = 7'h01 << code_cur;
  assign restart  = code_cur != seen_r[ch_r];
  assign hold_en  = cfg_r[ch_r][`AIC_CFG_HOLD_BIT];
  assign trig_hit = |(din_sync_r & trig_r[ch_r][`AIC_TRIG_W-1:0]);
  assign band     = (zero_r[ch_r] < 0) ? aic_val_type'(-zero_r[ch_r]) : zero_r[ch_r];

  aic_hist_mem #(
    .WIDTH  (16),
    .ADDR_W (7)
  ) u_hist (
    .clk   (aclk),
    .we    (state_r == AIC_S_AVG),
    .waddr ({ch_r, ptr_r[ch_r]}),
    .wdata (val_r),
    .raddr ({ch_r, ptr_r[ch_r] - n_cur[5:0]}),
    .rdata (old_sample)
  );

  always_comb begin
    // range conversion; the live-zero range maps 4..20 mA onto 0..100 %.
    if (aic_range_type'(cfg_r[ch_r][`AIC_CFG_RANGE_LSB +: 2]) == AIC_RANGE_MA4_20) begin
      rng_nxt = sat_val(((32'(adc_sync_r[ch_r]) - `AIC_LIVE_ZERO) * 5) >>> 2);
    end else begin
      rng_nxt = sat_val(32'(adc_sync_r[ch_r]));
    end
    // running sum drops the sample that fell out of the window.
    if (restart) begin
      sum_nxt  = 24'(val_r);
      fill_nxt = 7'h01;
    end else begin
      sum_nxt  = $signed(sum_r[ch_r]) + 24'(val_r) -
                 ((fill_r[ch_r] >= n_cur) ? 24'(signed'(old_sample)) : 24'sh000000);
      fill_nxt = (fill_r[ch_r] == 7'h40) ? 7'h40 : fill_r[ch_r] + 7'h01;
    end
    // until the window is full the newest sample is passed on.
    avg_nxt = (fill_nxt < n_cur) ? val_r : aic_val_type'(sum_nxt >>> code_cur);
    // replay the stored value while the trigger is low.
    hold_nxt = (hold_en && !trig_hit) ? held_r[ch_r] : val_r;
    zero_nxt = (val_r <= band && val_r >= -band) ? aic_val_type'(16'h0000) : val_r;
    // negative band also holds the previous setpoint against small changes.
    if (zero_r[ch_r] < 0 && (32'(zero_nxt) - 32'(last_r[ch_r]) <= 32'(band)) &&
        (32'(last_r[ch_r]) - 32'(zero_nxt) <= 32'(band))) begin
      zero_nxt = last_r[ch_r];
    end
    // gain times (input minus x offset) plus y offset, each step saturated.
    amp_nxt = sat_val(32'(sat_val(32'(val_r) - 32'(xoff_r[ch_r]))) * 32'(gain_r[ch_r])
                      / `AIC_GAIN_SCALE);
    amp_nxt = sat_val(32'(amp_nxt) + 32'(yoff_r[ch_r]));
    // no ordering check; the minimum wins when limits cross.
    lim_nxt = (val_r > max_r[ch_r]) ? max_r[ch_r] : val_r;
    lim_nxt = (lim_nxt < min_r[ch_r]) ? min_r[ch_r] : lim_nxt;
    // limits written beyond 400 % must not widen the value range.
    lim_nxt = sat_val(32'(lim_nxt));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= AIC_S_IDLE;
      ch_r    <= 1'b0;
      val_r   <= '0;
    end else begin
      case (state_r)
        AIC_S_IDLE: begin
          ch_r <= 1'b0;
          if (tick_r) begin
            state_r <= AIC_S_RANGE;
          end
        end
        AIC_S_RANGE: begin
          val_r   <= rng_nxt;
          state_r <= AIC_S_AVG;
        end
        AIC_S_AVG: begin
          val_r   <= avg_nxt;
          state_r <= AIC_S_HOLD;
        end
        AIC_S_HOLD: begin
          val_r   <= hold_nxt;
          state_r <= AIC_S_ZERO;
        end
        AIC_S_ZERO: begin
          val_r   <= zero_nxt;
          state_r <= AIC_S_AMP;
        end
        AIC_S_AMP: begin
          val_r   <= amp_nxt;
          state_r <= AIC_S_LIMIT;
        end
        AIC_S_LIMIT: begin
          val_r   <= lim_nxt;
          ch_r    <= 1'b1;
          state_r <= ch_r ? AIC_S_ROUTE : AIC_S_RANGE;
        end
        default: begin
          state_r <= AIC_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r  <= '{default: '0};
      fill_r <= '{default: '0};
      sum_r  <= '{default: '0};
      seen_r <= '{default: '0};
    end else if (state_r == AIC_S_AVG) begin
      ptr_r[ch_r]  <= ptr_r[ch_r] + 6'h01;
      fill_r[ch_r] <= fill_nxt;
      sum_r[ch_r]  <= sum_nxt;
      seen_r[ch_r] <= code_cur;
    end
  end

  // the store only follows the signal while save mode and trigger agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_r <= '{default: '0};
      last_r <= '{default: '0};
    end else begin
      if (state_r == AIC_S_HOLD && hold_en && trig_hit) begin
        held_r[ch_r] <= val_r;
      end
      if (state_r == AIC_S_ZERO) begin
        last_r[ch_r] <= zero_nxt;
      end
    end
  end

  // monitors before and after the amplifier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_pre_r  <= '{default: '0};
      mon_post_r <= '{default: '0};
    end else if (state_r == AIC_S_AMP) begin
      mon_pre_r[ch_r] <= val_r;
    end else if (state_r == AIC_S_LIMIT) begin
      mon_post_r[ch_r] <= lim_nxt;
    end
  end

  // route to reference and auxiliary outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_r   <= '0;
      aux_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= state_r == AIC_S_ROUTE;
      if (state_r == AIC_S_ROUTE) begin
        ref_r <= route_r ? mon_post_r[1] : mon_post_r[0];
        aux_r <= route_r ? mon_post_r[0] : mon_post_r[1];
      end
    end
  end

  assign ref_value   = ref_r;
  assign aux_value   = aux_r;
  assign value_valid = valid_r;

  AST_TICK_START: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_r && state_r == AIC_S_IDLE |=> state_r == AIC_S_RANGE && !ch_r)
    else $error("Sample tick did not start channel one.");
  AST_LIVE_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_RANGE && cfg_r[ch_r][1:0] == 2'h2 && adc_sync_r[ch_r] == 16'sh00c8
    |=> val_r == 16'sh0000)
    else $error("Four milliamp did not map to zero.");
  AST_AVG_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_AVG && code_cur == 3'h0 |=> val_r == $past(val_r))
    else $error("Averaging off altered the sample.");
  AST_HOLD_REPLAY: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_HOLD && hold_en && !trig_hit |=> val_r == $past(held_r[ch_r]))
    else $error("Save mode did not replay the stored value.");
  AST_ZERO_BAND: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_ZERO && zero_r[ch_r] >= 0 && val_r <= band && val_r >= -band
    |=> val_r == 16'sh0000)
    else $error("Value inside the zero band was not cleared.");
  AST_AMP_UNITY: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_AMP && gain_r[ch_r] == 16'sh0064 && xoff_r[ch_r] == 16'sh0000 &&
    yoff_r[ch_r] == 16'sh0000 |=> val_r == $past(val_r))
    else $error("Unity amplifier changed the value.");
  AST_LIMITS: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_LIMIT && min_r[ch_r] <= max_r[ch_r]
    |=> val_r >= $past(min_r[ch_r]) && val_r <= $past(max_r[ch_r]))
    else $error("Limited value outside its limits.");
  AST_SAT_400: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r inside {AIC_S_AVG, AIC_S_HOLD, AIC_S_ZERO, AIC_S_AMP, AIC_S_LIMIT, AIC_S_ROUTE}
    |-> val_r <= 16'sh0fa0 && val_r >= -16'sh0fa0)
    else $error("Internal value beyond 400 percent.");
  AST_ROUTE_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    valid_r |-> ref_r == ($past(route_r) ? mon_post_r[1] : mon_post_r[0]) &&
    aux_r == ($past(route_r) ? mon_post_r[0] : mon_post_r[1]))
    else $error("Reference or auxiliary routed wrongly.");
  AST_MON_POST: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == AIC_S_LIMIT |=> mon_post_r[$past(ch_r)] == val_r)
    else $error("Post amplifier monitor not updated.");

endmodule : aic_analog_cond

// ==== verif/aic_adc_model.sv ====
// Converter model that presents the two channel codes to the block.
// Assumes the bench changes a level only between samples.
module aic_adc_model (
  input  wire logic        aclk,
  input  wire logic [15:0] level_one,
  input  wire logic [15:0] level_two,
  output logic      [15:0] code_one,
  output logic      [15:0] code_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // A real converter latches its result, so the codes move one clock late.
  always_ff @(posedge aclk) begin
    code_one <= level_one;
    code_two <= level_two;
  end
endmodule : aic_adc_model

// ==== verif/tb_aic_analog_cond.sv ====
// Self-checking bench for the analog conditioning chain.
// Assumes a 40-clock sample period so that many samples fit in a short run.
module tb_aic_analog_cond;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, brd = 1'h0;
  logic        arv = 1'h0, rrd = 1'h0, awr, wr, bv, arr, rv, vv;
  logic [11:0] awa = 12'h000, ara = 12'h000, pins = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic [15:0] lvl1 = 16'h0000, lvl2 = 16'h0123, an1, an2, ref_v, aux_v;
  logic [1:0]  br, rr;
  int          fail_count = 0, samples_checked = 0;
  logic [11:0] ra [5] = '{12'h00c, 12'h010, 12'h014, 12'h008, 12'h01c};
  // Columns: input, gain, x offset, y offset, zero band, maximum, expected.
  logic [15:0] rows [7][7] = '{
    '{16'h01f4, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0fa0, 16'h01f4},
    '{16'h03e8, 16'h00c8, 16'h01f4, 16'h0000, 16'h0000, 16'h0fa0, 16'h03e8},
    '{16'hfe0c, 16'hff9c, 16'h0000, 16'h03e8, 16'h0000, 16'h0fa0, 16'h05dc},
    '{16'h0bb8, 16'h00c8, 16'h0000, 16'h0000, 16'h0000, 16'h0fa0, 16'h0fa0},
    '{16'h0258, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h012c, 16'h012c},
    '{16'h0032, 16'h0064, 16'h0000, 16'h0000, 16'h0064, 16'h0fa0, 16'h0000},
    '{16'hffce, 16'h0064, 16'h0000, 16'h0000, 16'h0064, 16'h0fa0, 16'h0000}};

  aic_adc_model aic_adc_model_inst (.aclk(aclk), .level_one(lvl1), .level_two(lvl2),
    .code_one(an1), .code_two(an2));
  aic_analog_cond #(.SAMPLE_CYCLES(40)) aic_analog_cond_inst (.aclk(aclk), .aresetn(rstn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .analog_channel_one(an1),
    .analog_channel_two(an2), .prog_inputs(pins), .ref_value(ref_v), .aux_value(aux_v),
    .value_valid(vv));

  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; the response comes with awready.
  task automatic axw(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd  <= {16'h0000, d};
    awv <= 1'h1;
    wv  <= 1'h1;
    brd <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr === 1'h1) awv <= 1'h0;
      if (wr === 1'h1) wv <= 1'h0;
    end while (bv !== 1'h1);
    chk({30'h0, br}, {30'h0, er});
    brd <= 1'h0;
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr === 1'h1) arv <= 1'h0;
    end while (rv !== 1'h1);
    chk(rd, exp);
    chk({30'h0, rr}, {30'h0, er});
    rrd <= 1'h0;
  endtask : axr

  task automatic samp(input int n);
    repeat (n) do @(posedge aclk); while (vv !== 1'h1);
  endtask : samp

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge aclk);
    rstn <= 1'h1;
    axr(12'h00c, 32'h00000064, 2'h0);
    axr(12'h018, 32'h0000f060, 2'h0);
    axw(12'h0fc, 16'h1234, 2'h2);
    axr(12'h0fc, 32'h00000000, 2'h2);
    $display("reset and map test done");
    foreach (rows[i]) begin
      for (int k = 0; k < 5; k++) axw(ra[k], rows[i][k+1], 2'h0);
      lvl1 <= rows[i][0];
      samp(2);
      chk({16'h0000, ref_v}, {16'h0000, rows[i][6]});
    end
    $display("row test done");
    axw(12'h080, 16'h0001, 2'h0);
    samp(2);
    chk({16'h0000, ref_v}, 32'h00000123);
    axw(12'h080, 16'h0000, 2'h0);
    axw(12'h040, 16'h0002, 2'h0);
    lvl2 <= 16'h0258;
    samp(2);
    chk({16'h0000, aux_v}, 32'h000001f4);
    lvl2 <= 16'h00c8;
    samp(2);
    chk({16'h0000, aux_v}, 32'h00000000);
    axw(12'h048, 16'hff9c, 2'h0);
    lvl2 <= 16'h0190;
    samp(2);
    chk({16'h0000, aux_v}, 32'h000000fa);
    lvl2 <= 16'h01c2;
    samp(2);
    chk({16'h0000, aux_v}, 32'h000000fa);
    axw(12'h000, 16'h0004, 2'h0);
    lvl1 <= 16'h0078;
    samp(3);
    lvl1 <= 16'h0118;
    samp(1);
    chk({16'h0000, ref_v}, 32'h000000c8);
    axw(12'h000, 16'h0100, 2'h0);
    axw(12'h004, 16'h0001, 2'h0);
    pins <= 12'h001;
    lvl1 <= 16'h0190;
    samp(2);
    chk({16'h0000, ref_v}, 32'h00000190);
    pins <= 12'h000;
    samp(1);
    lvl1 <= 16'h0258;
    samp(2);
    chk({16'h0000, ref_v}, 32'h00000190);
    axr(12'h020, 32'h00000190, 2'h0);
    $display("route range average hold test done");
    rstn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk({16'h0000, ref_v}, 32'h00000000);
    rstn <= 1'h1;
    axr(12'h000, 32'h00000000, 2'h0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : tb_aic_analog_cond
